//--- design/buck_ctrl.sv
/*
 * Digital control of a stackable step-down converter: start-up sequence,
 * open-drain enable and stack-ready pin, operating mode choice, soft
 * start with deferred setting writes, clock-aligned gate pulses.
 * Assumes host register writes arrive as one-cycle strobes in clk domain,
 * and that sys_rst is the supply undervoltage lockout.
 */
`timescale 1ns/100ps
`default_nettype none
module buck_ctrl
	import buck_ctrl_pkg::*;
#(
	parameter int RAMP0_CYC = SS_T0_CYC,
	parameter int RAMP1_CYC = SS_T1_CYC,
	parameter int RAMP2_CYC = SS_T2_CYC,
	parameter int RAMP3_CYC = SS_T3_CYC
) (
	input  wire logic            clk,
	input  wire logic            sys_rst,
	input  wire logic            mode_sync_pin,
	input  wire logic            enable_pin_in,
	output logic                 enable_pin_out,
	output logic                 enable_pin_oe,
	input  wire logic [1:0]      voltage_strap_pin,
	input  wire logic [1:0]      frequency_strap_pin,
	input  wire logic            sync_out_strap_pin,
	input  wire logic            nvm_ready,
	input  wire logic [3:0][7:0] nvm_setpoint_table,
	input  wire logic            fault_thermal,
	input  wire logic            fault_overvoltage,
	input  wire logic            standalone_select,
	input  wire logic            forced_pwm_select,
	input  wire logic            spread_spectrum_en,
	input  wire logic            wr_setpoint,
	input  wire logic [7:0]      wr_setpoint_data,
	input  wire logic            wr_range,
	input  wire logic [1:0]      wr_range_data,
	input  wire logic            wr_duration,
	input  wire logic [1:0]      wr_duration_data,
	input  wire logic [1:0]      load_level,
	input  wire logic            pulse_demand,
	input  wire logic [7:0]      on_time_req,
	input  wire logic [7:0]      output_level_code,
	output logic                 reference_enable,
	output logic                 i2c_enable,
	output strap_t               strap_state,
	output setting_t             staged_setting,
	output setting_t             active_setting,
	output logic                 ready_n,
	output logic                 converter_enable,
	output logic                 ramp_active,
	output logic [7:0]           reference_level,
	output logic                 forced_pwm_operation,
	output logic                 power_save_operation,
	output conduction_t          conduction,
	output logic                 high_side_gate
);
	// Synchronised pins
	logic        mode_level;
	logic        en_level;
	logic [1:0]  fault_level;
	strap_t      strap_level;

	pin_sync #(.W(1)) u_mode_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pin     (mode_sync_pin),
		.level   (mode_level)
	);

	pin_sync #(.W(1)) u_en_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pin     (enable_pin_in),
		.level   (en_level)
	);

	pin_sync #(.W(2)) u_fault_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pin     ({fault_overvoltage, fault_thermal}),
		.level   (fault_level)
	);

	pin_sync #(.W(5)) u_strap_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pin     ({voltage_strap_pin, frequency_strap_pin,
			sync_out_strap_pin}),
		.level   (strap_level)
	);

	// Start-up sequence
	init_state_t      init_state;
	init_state_t      next_init_state;
	logic [CNT_W-1:0] init_cnt;
	wire              init_complete;
	wire              ref_settled;

	assign init_complete = (init_state == init_done);
	assign ref_settled   = (init_cnt >= CNT_W'(REF_SETTLE_CYC - 1));

	always_comb begin
		next_init_state = init_state;
		case (init_state)
			init_hold:      next_init_state = init_reference;
			init_reference: begin
				if (ref_settled) next_init_state = init_sample;
			end
			init_sample:    next_init_state = init_load;
			init_load:      begin
				if (nvm_ready) next_init_state = init_done;
			end
			default:        next_init_state = init_done;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			init_state <= init_hold;
			init_cnt   <= '0;
		end else begin
			init_state <= next_init_state;
			if (init_state == init_reference && !ref_settled)
				init_cnt <= init_cnt + CNT_W'(1);
		end
	end

	// Straps are caught once; nothing but undervoltage lockout clears them
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			strap_state      <= '0;
			reference_enable <= 1'b0;
			i2c_enable       <= 1'b0;
		end else begin
			if (init_state == init_sample)
				strap_state <= strap_level;
			reference_enable <= (init_state != init_hold);
			i2c_enable       <= (next_init_state == init_done);
		end
	end

	// Enable pin: open drain, driven only to low
	wire fault_any;
	wire fault_enabled;
	wire next_ready_n;

	assign fault_any     = |fault_level;
	assign fault_enabled = fault_any & ~standalone_select;
	assign next_ready_n  =
		~((next_init_state == init_done) & ~fault_enabled);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ready_n        <= 1'b1;
			enable_pin_out <= 1'b0;
			enable_pin_oe  <= 1'b1;
		end else begin
			ready_n        <= next_ready_n;
			enable_pin_out <= 1'b0;
			enable_pin_oe  <= next_ready_n;
		end
	end

	// Host settings: staged copy and the copy the converter uses
	logic [1:0] range_pending;
	wire        settings_frozen;

	assign settings_frozen = ramp_active;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			staged_setting <= SETTING_RESET;
			range_pending  <= RANGE_RESET;
		end else if (init_state == init_load && nvm_ready) begin
			staged_setting.output_setpoint_code <=
				nvm_setpoint_table[strap_state.voltage_strap];
		end else if (init_complete) begin
			if (wr_range)
				range_pending <= wr_range_data;
			if (wr_setpoint) begin
				staged_setting.output_setpoint_code <= wr_setpoint_data;
				// A new range waits for the setpoint write after it
				staged_setting.voltage_range_select <= range_pending;
			end
			if (wr_duration)
				staged_setting.soft_start_duration <= wr_duration_data;
		end
	end

	// Converter sequencing
	conv_state_t      conv_state;
	conv_state_t      next_conv_state;
	logic [CNT_W-1:0] delay_cnt;
	wire              run_allowed;
	wire              delay_done;
	wire              ramp_busy;
	wire [7:0]        ramp_level;
	wire              ramp_start;

	// The wired pin is low while any stacked device is not ready
	assign run_allowed = init_complete & en_level & ~fault_any;
	assign delay_done  = (delay_cnt >= CNT_W'(START_DELAY_CYC - 1));
	assign ramp_start  = (conv_state == conv_wait) && delay_done;

	always_comb begin
		next_conv_state = conv_state;
		case (conv_state)
			conv_off:  begin
				if (run_allowed) next_conv_state = conv_wait;
			end
			conv_wait: begin
				if (delay_done) next_conv_state = conv_ramp;
			end
			conv_ramp: begin
				if (!ramp_busy && !ramp_start)
					next_conv_state = conv_run;
			end
			default:   next_conv_state = conv_run;
		endcase
		if (!run_allowed)
			next_conv_state = conv_off;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			conv_state <= conv_off;
			delay_cnt  <= '0;
		end else begin
			conv_state <= next_conv_state;
			if (conv_state == conv_wait && !delay_done)
				delay_cnt <= delay_cnt + CNT_W'(1);
			else if (conv_state != conv_wait)
				delay_cnt <= '0;
		end
	end

	// Settings in use follow the staged copy every cycle except during the ramp, when they are held
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			active_setting <= SETTING_RESET;
		end else if (!settings_frozen) begin
			active_setting <= staged_setting;
		end
	end

	soft_start_ramp #(
		.RAMP0_CYC (RAMP0_CYC),
		.RAMP1_CYC (RAMP1_CYC),
		.RAMP2_CYC (RAMP2_CYC),
		.RAMP3_CYC (RAMP3_CYC)
	) u_ramp (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.run      (conv_state == conv_ramp || conv_state == conv_run ||
			ramp_start),
		.start    (ramp_start),
		.target   (active_setting.output_setpoint_code),
		.duration (active_setting.soft_start_duration),
		.level    (ramp_level),
		.busy     (ramp_busy)
	);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ramp_active      <= 1'b0;
			converter_enable <= 1'b0;
			reference_level  <= 8'h00;
		end else begin
			ramp_active      <= (next_conv_state == conv_ramp);
			converter_enable <= (next_conv_state == conv_ramp) ||
				(next_conv_state == conv_run);
			reference_level  <= ramp_level;
		end
	end

	// Operating mode
	logic [CNT_W-1:0] sync_age;
	logic             mode_prev;
	wire              mode_edge;
	wire              sync_present;
	wire              forced_mode;
	conduction_t      next_conduction;

	assign mode_edge    = mode_level & ~mode_prev;
	assign sync_present = (sync_age < CNT_W'(SYNC_LOSS_CYC));
	// Sync clock, high pin, bit or spread spectrum all force PWM
	assign forced_mode  = mode_level | sync_present |
		forced_pwm_select | spread_spectrum_en;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_prev <= 1'b0;
			sync_age  <= CNT_W'(SYNC_LOSS_CYC);
		end else begin
			mode_prev <= mode_level;
			if (mode_edge)
				sync_age <= '0;
			else if (sync_present)
				sync_age <= sync_age + CNT_W'(1);
		end
	end

	always_comb begin
		next_conduction = conduction_idle;
		if (next_conv_state == conv_ramp)
			next_conduction = pwm_discontinuous_conduction;
		else if (next_conv_state == conv_run) begin
			if (forced_mode)
				next_conduction = pwm_continuous_conduction;
			else if (load_level == 2'h0)
				next_conduction = pulse_skip_discontinuous;
			else if (load_level == 2'h1)
				next_conduction = pwm_discontinuous_conduction;
			else
				next_conduction = pwm_continuous_conduction;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			forced_pwm_operation <= 1'b1;
			power_save_operation <= 1'b0;
			conduction           <= conduction_idle;
		end else begin
			forced_pwm_operation <= forced_mode;
			power_save_operation <= ~forced_mode;
			conduction           <= next_conduction;
		end
	end

	// Gate pulses on the internal switching clock
	logic [7:0] sw_cnt;
	logic [7:0] on_cnt;
	wire        sw_tick;
	wire        pulse_busy;
	wire        switching;
	wire        want_pulse;
	wire [7:0]  pulse_len;

	assign sw_tick    = (sw_cnt == 8'h00);
	assign pulse_busy = (on_cnt != 8'h00);
	// During the ramp nothing switches until the reference clears the
	// existing output, so a prebiased rail is not pulled down
	assign switching  = (conduction != conduction_idle) &&
		!(ramp_active && reference_level <= output_level_code);
	assign want_pulse = (conduction == pulse_skip_discontinuous) ?
		pulse_demand : 1'b1;
	// Too short a request is stretched, never cut
	assign pulse_len  = (on_time_req < 8'(MIN_ON_CYC)) ?
		8'(MIN_ON_CYC) : on_time_req;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sw_cnt <= 8'h00;
		end else if (sw_cnt == 8'(SW_PERIOD_CYC - 1)) begin
			sw_cnt <= 8'h00;
		end else begin
			sw_cnt <= sw_cnt + 8'h01;
		end
	end

	// A tick that lands inside a running pulse is skipped, which
	// lowers the effective switching frequency
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			on_cnt         <= 8'h00;
			high_side_gate <= 1'b0;
		end else if (!switching) begin
			on_cnt         <= 8'h00;
			high_side_gate <= 1'b0;
		end else if (pulse_busy) begin
			on_cnt         <= on_cnt - 8'h01;
			high_side_gate <= 1'b1;
		end else if (sw_tick && want_pulse) begin
			on_cnt         <= pulse_len - 8'h01;
			high_side_gate <= 1'b1;
		end else begin
			high_side_gate <= 1'b0;
		end
	end

endmodule : buck_ctrl
`default_nettype wire

//--- design/buck_ctrl_pkg.sv
/*
 * Shared constants and types for the step-down converter control block:
 * timing counts, reset values, strap and setting records, state types.
 * Assumes a 10 MHz control clock; all counts except SW_PERIOD_CYC derive from its period.
 */
package buck_ctrl_pkg;

	localparam int CLK_PERIOD_NS   = 100;
	localparam int MIN_ON_NS       = 50;
	localparam int MIN_ON_CYC      =
		(MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SS_T0_US        = 500;
	localparam int SS_T1_US        = 1000;
	localparam int SS_T2_US        = 2000;
	localparam int SS_T3_US        = 4000;
	localparam int SS_T0_CYC       = SS_T0_US * 1000 / CLK_PERIOD_NS;
	localparam int SS_T1_CYC       = SS_T1_US * 1000 / CLK_PERIOD_NS;
	localparam int SS_T2_CYC       = SS_T2_US * 1000 / CLK_PERIOD_NS;
	localparam int SS_T3_CYC       = SS_T3_US * 1000 / CLK_PERIOD_NS;
	localparam int START_DELAY_US  = 20;
	localparam int START_DELAY_CYC =
		START_DELAY_US * 1000 / CLK_PERIOD_NS;
	localparam int REF_SETTLE_US   = 10;
	localparam int REF_SETTLE_CYC  =
		REF_SETTLE_US * 1000 / CLK_PERIOD_NS;
	localparam int SYNC_LOSS_NS    = 2000;
	localparam int SYNC_LOSS_CYC   = SYNC_LOSS_NS / CLK_PERIOD_NS;
	localparam int SW_PERIOD_CYC   = 4;
	localparam int CNT_W           = 16;

	localparam logic [7:0] SETPOINT_RESET = 8'h00;
	localparam logic [1:0] RANGE_RESET    = 2'h2;
	localparam logic [1:0] SS_TIME_RESET  = 2'h1;

	typedef struct packed {
		logic [1:0] voltage_strap;
		logic [1:0] frequency_strap;
		logic       sync_out_strap;
	} strap_t;

	typedef struct packed {
		logic [7:0] output_setpoint_code;
		logic [1:0] voltage_range_select;
		logic [1:0] soft_start_duration;
	} setting_t;

	localparam setting_t SETTING_RESET =
		'{SETPOINT_RESET, RANGE_RESET, SS_TIME_RESET};

	typedef enum logic [1:0] {
		conduction_idle,
		pwm_continuous_conduction,
		pwm_discontinuous_conduction,
		pulse_skip_discontinuous
	} conduction_t;

	typedef enum logic [2:0] {
		init_hold, init_reference, init_sample, init_load, init_done
	} init_state_t;

	typedef enum logic [1:0] {
		conv_off, conv_wait, conv_ramp, conv_run
	} conv_state_t;

endpackage : buck_ctrl_pkg

//--- design/pin_sync.sv
/*
 * Three-stage input synchroniser for pins from outside the clock domain.
 * The output follows only once the second and third stages agree.
 * Assumes the input is a slow level, not a pulse shorter than two cycles.
 */
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] level
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1    <= '0;
			s2    <= '0;
			s3    <= '0;
			level <= '0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			// Each bit moves only when the last two stages agree
			level <= (s2 & s3) | (level & (s2 | s3));
		end
	end
endmodule : pin_sync
`default_nettype wire

//--- design/soft_start_ramp.sv
/*
 * Reference ramp: climbs from zero to a target at the rate that spans full scale in the chosen duration,
 * then steps up or down toward later targets at the same rate.
 * Assumes the caller holds the target stable while busy is high.
 */
`timescale 1ns/100ps
`default_nettype none
module soft_start_ramp
	import buck_ctrl_pkg::*;
#(
	parameter int RAMP0_CYC = SS_T0_CYC,
	parameter int RAMP1_CYC = SS_T1_CYC,
	parameter int RAMP2_CYC = SS_T2_CYC,
	parameter int RAMP3_CYC = SS_T3_CYC
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       run,
	input  wire logic       start,
	input  wire logic [7:0] target,
	input  wire logic [1:0] duration,
	output logic      [7:0] level,
	output logic            busy
);
	logic [CNT_W-1:0] div;
	wire  [CNT_W-1:0] step_len;
	wire              step;

	// Full scale of 256 codes spread over the ramp time
	assign step_len = (duration == 2'h0) ? CNT_W'(RAMP0_CYC / 256) :
		(duration == 2'h1) ? CNT_W'(RAMP1_CYC / 256) :
		(duration == 2'h2) ? CNT_W'(RAMP2_CYC / 256) :
		CNT_W'(RAMP3_CYC / 256);
	assign step = (div >= step_len - CNT_W'(1));

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			level <= 8'h00;
			busy  <= 1'b0;
			div   <= '0;
		end else if (!run || start) begin
			level <= 8'h00;
			busy  <= start;
			div   <= '0;
		end else if (step) begin
			div <= '0;
			if (level < target) level <= level + 8'h01;
			else if (level > target && !busy) level <= level - 8'h01;
			// Busy drops on the step that lands on the target, so the
			// ramp to a nonzero target lasts exactly target codes times the step length
			if (busy && (level == target || level + 8'h01 == target))
				busy <= 1'b0;
		end else begin
			div <= div + CNT_W'(1);
		end
	end
endmodule : soft_start_ramp
`default_nettype wire

//--- sim/buck_ctrl_sva.sv
/*
 * Port checker for the converter control block.
 * Assumes one clock domain and attachment by bind to every buck_ctrl.
 */
`timescale 1ns/100ps
`default_nettype none
module buck_ctrl_sva
	import buck_ctrl_pkg::*;
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        forced_pwm_select,
	input wire logic        spread_spectrum_en,
	input wire logic [7:0]  output_level_code,
	input wire logic        enable_pin_oe,
	input wire logic        reference_enable,
	input wire logic        i2c_enable,
	input wire setting_t    active_setting,
	input wire logic        ready_n,
	input wire logic        converter_enable,
	input wire logic        ramp_active,
	input wire logic [7:0]  reference_level,
	input wire logic        forced_pwm_operation,
	input wire logic        power_save_operation,
	input wire conduction_t conduction,
	input wire logic        high_side_gate
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_pin_ready; enable_pin_oe == ready_n; endproperty
	property p_init_hold; !i2c_enable |-> enable_pin_oe; endproperty
	property p_order; i2c_enable |-> reference_enable; endproperty
	property p_forced;
		(forced_pwm_select || spread_spectrum_en) [*3]
			|-> forced_pwm_operation && !power_save_operation;
	endproperty
	property p_ramp_disc;
		ramp_active |-> conduction == pwm_discontinuous_conduction;
	endproperty
	property p_forced_ccm;
		(forced_pwm_operation && converter_enable && !ramp_active) [*3]
			|-> conduction == pwm_continuous_conduction;
	endproperty
	property p_hold_active; ramp_active [*2] |-> $stable(active_setting);
	endproperty
	property p_off_gate; !converter_enable [*2] |-> !high_side_gate;
	endproperty
	property p_fault_off; ready_n [*4] |-> !converter_enable; endproperty
	property p_prebias;
		(ramp_active && reference_level <= output_level_code) [*2]
			|-> !high_side_gate;
	endproperty
	// A ramp cut short by the pin is excluded by the enable term
	property p_ramp_end;
		$fell(ramp_active) && converter_enable
			|-> reference_level == $past(active_setting.output_setpoint_code);
	endproperty
	a_pin_ready: assert property (p_pin_ready)
		else $error("pin drive differs from ready");
	a_init_hold: assert property (p_init_hold)
		else $error("pin released before init end");
	a_order: assert property (p_order)
		else $error("interface up without reference");
	a_forced: assert property (p_forced)
		else $error("power save while forced");
	a_ramp_disc: assert property (p_ramp_disc)
		else $error("ramp not discontinuous");
	a_forced_ccm: assert property (p_forced_ccm)
		else $error("forced mode not continuous");
	a_hold_active: assert property (p_hold_active)
		else $error("setting moved during ramp");
	a_off_gate: assert property (p_off_gate)
		else $error("gate pulse while off");
	a_fault_off: assert property (p_fault_off)
		else $error("converter on while not ready");
	a_prebias: assert property (p_prebias)
		else $error("switching below prebias");
	a_ramp_end: assert property (p_ramp_end)
		else $error("ramp ended off target");
	c_ramp: cover property ($fell(ramp_active) && converter_enable);
	c_skip: cover property (conduction == pulse_skip_discontinuous);
	c_gate: cover property ($rose(high_side_gate));
	c_fault: cover property ($rose(ready_n));
endmodule : buck_ctrl_sva
bind buck_ctrl buck_ctrl_sva u_sva (.clk, .sys_rst, .forced_pwm_select,
	.spread_spectrum_en, .output_level_code, .enable_pin_oe,
	.reference_enable, .i2c_enable, .active_setting, .ready_n,
	.converter_enable, .ramp_active, .reference_level,
	.forced_pwm_operation, .power_save_operation, .conduction,
	.high_side_gate);
`default_nettype wire

//--- sim/buck_ctrl_tb_top.sv
/*
 * Self-checking bench: start-up, enable line, soft start, modes, faults.
 * Assumes the enable line model and the bound checker.
 */
`timescale 1ns/100ps
`default_nettype none
module buck_ctrl_tb_top
	import buck_ctrl_pkg::*;
;
	localparam int RC [4] = '{512, 1024, 2048, 4096};
	logic            clk = 0, sys_rst = 1, mode_sync_pin = 0, nvm_ready = 0;
	logic            fault_thermal = 0, fault_overvoltage = 0;
	logic            standalone_select = 0, forced_pwm_select = 0;
	logic            spread_spectrum_en = 0, pulse_demand = 0;
	logic            wr_setpoint = 0, wr_range = 0, wr_duration = 0;
	logic            host_low = 1, peer_low = 0, sync_out_strap_pin = 1;
	logic [1:0]      voltage_strap_pin = 2'h1, frequency_strap_pin = 2'h2;
	logic [1:0]      wr_range_data = 0, wr_duration_data = 0, load_level = 0;
	logic [7:0]      wr_setpoint_data = 0, on_time_req = 8'h02;
	logic [7:0]      output_level_code = 0, reference_level;
	logic [3:0][7:0] nvm_setpoint_table = {8'h40, 8'h30, 8'h18, 8'h10};
	logic            enable_pin_in, enable_pin_out, enable_pin_oe, ready_n;
	logic            reference_enable, i2c_enable, converter_enable;
	logic            ramp_active, high_side_gate;
	logic            forced_pwm_operation, power_save_operation;
	strap_t          strap_state;
	setting_t        staged_setting, active_setting;
	conduction_t     conduction;
	int              bad_count = 0, compares = 0, i, n;
	always #50 clk = ~clk;
	buck_ctrl #(.RAMP0_CYC(RC[0]), .RAMP1_CYC(RC[1]), .RAMP2_CYC(RC[2]),
		.RAMP3_CYC(RC[3])) u_dut (.*);
	enable_line_model u_line (.enable_pin_out, .enable_pin_oe,
		.host_drive_low(host_low), .peer_hold_low(peer_low),
		.enable_level(enable_pin_in));
	task summarize;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	task check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : step
	// One strobe per call; k picks setpoint, range or duration
	task wr(input int k, input logic [7:0] d);
		{wr_setpoint, wr_range, wr_duration} = 3'b100 >> k;
		{wr_setpoint_data, wr_range_data, wr_duration_data} = {d, d[1:0], d[1:0]};
		step(1);
		{wr_setpoint, wr_range, wr_duration} = '0;
		step(1);
	endtask : wr
	task automatic wait_hi(ref logic s, input int bound);
		for (int j = 0; j < bound && s !== 1'b1; j++)
			step(1);
		if (s !== 1'b1) begin
			bad_count++;
			$display("CHECK FAILED %0t wait ran out", $time);
			summarize();
		end
	endtask : wait_hi
	initial begin
		step(8);
		check(enable_pin_oe, 1);
		step(8);
		sys_rst = 0;
		wr(0, 8'h77);
		step(200);
		check({enable_pin_out, enable_pin_oe, i2c_enable, reference_enable},
			4'b0101);
		nvm_ready = 1;
		wait_hi(i2c_enable, 20);
		check({ready_n, enable_pin_oe}, 0);
		check(staged_setting, {8'h18, 2'h2, 2'h1});
		check(strap_state, {2'h1, 2'h2, 1'b1});
		wr(0, 8'h20);
		check({active_setting, converter_enable}, {8'h20, 4'h9, 1'b0});
		for (i = 0; i < 8; i++) begin
			{mode_sync_pin, forced_pwm_select, spread_spectrum_en} = i[2:0];
			step(8);
			check({power_save_operation, forced_pwm_operation}, {i == 0, i != 0});
		end
		{mode_sync_pin, forced_pwm_select, spread_spectrum_en} = 0;
		repeat (10) begin
			mode_sync_pin = ~mode_sync_pin;
			step(2);
		end
		check(forced_pwm_operation, 1);
		mode_sync_pin = 0;
		step(40);
		for (i = 0; i < 4; i++) begin
			wr(2, i);
			output_level_code = (i == 1) ? 8'h10 : 8'h00;
			host_low = 0;
			wait_hi(ramp_active, 260);
			check({conduction, converter_enable},
				{pwm_discontinuous_conduction, 1'b1});
			if (i == 3) begin
				wr(1, 3);
				wr(0, 8'h30);
				check(active_setting, {8'h20, 2'h2, 2'h3});
			end
			for (n = 0; ramp_active === 1'b1 && n < 3000; n++)
				step(1);
			check(n >= RC[i] / 8 - 8 && n <= RC[i] / 8 + 8, 1);
			if (i < 3) begin
				host_low = 1;
				step(8);
				check({converter_enable, reference_level}, 0);
			end
		end
		step(2);
		check(active_setting, {8'h30, 2'h3, 2'h3});
		for (i = 0; i < 8; i++) begin
			{forced_pwm_select, load_level} = i[2:0];
			step(6);
			check(conduction, (i[2] || i[1]) ? pwm_continuous_conduction :
				i[0] ? pwm_discontinuous_conduction : pulse_skip_discontinuous);
		end
		{forced_pwm_select, load_level} = 0;
		// Let the last forced-mode pulse finish before counting
		step(4);
		for (i = 0; i < 32; i++) begin
			pulse_demand = i[4];
			n = (i[3:0] == 0) ? 0 : n + high_side_gate;
			step(1);
			if (i[3:0] == 15)
				check(n > 0, i[4]);
		end
		for (i = 0; i < 4; i++) begin
			standalone_select = i[1];
			{fault_thermal, fault_overvoltage} = i[0] ? 2'b01 : 2'b10;
			step(8);
			check({enable_pin_oe, converter_enable}, {!i[1], 1'b0});
			{fault_thermal, fault_overvoltage} = 0;
			step(8);
			check(enable_pin_oe, 0);
		end
		standalone_select = 0;
		peer_low = 1;
		step(8);
		check(converter_enable, 0);
		peer_low = 0;
		wait_hi(ramp_active, 260);
		check(staged_setting, {8'h30, 2'h3, 2'h3});
		summarize();
	end
endmodule : buck_ctrl_tb_top
`default_nettype wire

//--- sim/enable_line_model.sv
/*
 * Shared open-drain enable line of a stack, with pull-up.
 * Assumes the other stacked device keeps standalone at 0 and is in
 * forced mode, so its fault or init shows only as a low hold.
 */
`timescale 1ns/100ps
`default_nettype none
module enable_line_model (
	input  wire logic enable_pin_out,
	input  wire logic enable_pin_oe,
	input  wire logic host_drive_low,
	input  wire logic peer_hold_low,
	output logic      enable_level
);
	// Pull-up wins only when no party sinks the line
	assign enable_level = !((enable_pin_oe && !enable_pin_out) ||
		host_drive_low || peer_hold_low);
endmodule : enable_line_model
`default_nettype wire
